// ### ipr_trap_lock_params.svh
// Constants: register offsets, field positions, reset values, cycle and instruction counts
`ifndef IPR_TRAP_LOCK_PARAMS_SVH
`define IPR_TRAP_LOCK_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define REG_FETCH_CTL     5'h00
`define REG_DATA_CTL      5'h04
`define REG_STATUS        5'h08
`define REG_EXCEPTION_ADDRESS_LO   5'h0C
`define REG_EXCEPTION_ADDRESS_HI   5'h10
`define REG_EXC_SUMMARY   5'h14
`define REG_MEM_FAULT     5'h18
`define REG_FAULT_FORM    5'h1C

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CTL_WIDE_BIT      0
`define CTL_NARROW_BIT    1
`define CTL_RESET         2'h0
`define NARROW_TOP_BIT    42
`define WIDE_TOP_BIT      47

// ---------------------------------------------------------------
// Cycle and instruction counts
// ---------------------------------------------------------------
`define RMW_MIN_CYCLES    4
`define RMW_MAX_CYCLES    9
`define LOCK_INSNS        4

`endif

// ### ipr_trap_lock_pkg.sv
// Types shared by the scoreboard, replay and trap lock block
package ipr_trap_lock_pkg;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } avs_rsp_t;

   typedef struct packed {
      logic dtb_double_wide;
      logic jsr_cmp_wide;
      logic vpc_wide;
      logic fetch_acv_wide;
      logic fetch_form_wide;
      logic fetch_form_narrow;
      logic data_form_wide;
      logic data_acv_wide;
      logic data_form_narrow;
   } addr_mode_t;

   typedef enum logic [0:0] {LOCK_OPEN, LOCK_HELD} lock_state_t;

endpackage

// ### ipr_scoreboard_trap_lock.sv
// Scoreboard, replay ordering, trap lock and address-width mode control
//
// Notes on behaviour
// - Read-modify-write issue gap four to nine cycles
// - Replayed memory op issues before newer ones
// - Replayed float store skips dirty check
// - Replay slot cancels next same-slot check
// - Illegal fetch only from privileged jump/return
// - Fetch wide bit selects fetch-side widths
// - Data wide bit selects data-side widths
// - Fetch control value applies after write retires
// - Trap locks exception state for four instructions
// - Delimiting instruction retire unlocks exception state
// - Exception while locked becomes replay trap
// - Data fault registers stay writable, unlocked
`timescale 1ns/1ns
`include "ipr_trap_lock_params.svh"

module ipr_scoreboard_trap_lock #(
   parameter int GROUPS = 8,
   parameter int PC_W   = 64
) (
   // Clock and reset
   input  wire logic                             clk,
   input  wire logic                             rst,
   // Register bus
   input  wire ipr_trap_lock_pkg::avs_req_t      avs_req,
   output      ipr_trap_lock_pkg::avs_rsp_t      avs_rsp_q,
   // Scoreboard
   input  wire logic                             sb_wr_issue,
   input  wire logic [$clog2(GROUPS)-1:0]        sb_wr_group,
   input  wire logic                             sb_wr_retire,
   input  wire logic [$clog2(GROUPS)-1:0]        sb_retire_group,
   output      logic [GROUPS-1:0]                sb_busy_q,
   // Read-modify-write sequencing
   input  wire logic                             rmw_rd_issue,
   input  wire logic                             rmw_wr_ready,
   output      logic                             rmw_wr_issue_q,
   // Replay trap
   input  wire logic                             replay_trap,
   input  wire logic [1:0]                       replay_pc,
   input  wire logic                             refetch_issue,
   input  wire logic                             iq_enq_valid,
   input  wire logic [1:0]                       iq_enq_pc,
   output      logic                             mem_issue_block_q,
   output      logic                             dirty_check_cancel_q,
   // Address width
   input  wire logic                             priv_jsr,
   input  wire logic                             priv_ret_to_priv,
   input  wire logic [PC_W-1:0]                  fetch_target,
   input  wire logic                             data_va_valid,
   input  wire logic [PC_W-1:0]                  data_va,
   input  wire logic                             fetch_ctl_retire,
   output      logic                             fetch_illegal_q,
   output      logic                             data_acv_q,
   output      ipr_trap_lock_pkg::addr_mode_t    addr_mode_q,
   // Exceptions
   input  wire logic                             exc_event,
   input  wire logic [PC_W-1:0]                  exc_pc,
   input  wire logic [31:0]                      exc_summary_in,
   input  wire logic [31:0]                      exc_fetch_form_in,
   input  wire logic                             pal_retire,
   input  wire logic                             pal_taken_branch,
   input  wire logic                             dfault_event,
   input  wire logic [31:0]                      dfault_status,
   input  wire logic [31:0]                      dfault_form,
   output      logic                             exc_trap_q,
   output      logic                             exc_replay_q,
   output      logic                             lock_q
);

   initial begin
      if (GROUPS < 2 || GROUPS > 16) $error("GROUPS out of range");
      if (PC_W != 64) $error("PC_W must be 64");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic ext_ok(input logic [PC_W-1:0] a, input logic wide);
      logic [PC_W-1:0] n;
      logic [PC_W-1:0] w;
      n = {{(PC_W-`NARROW_TOP_BIT-1){a[`NARROW_TOP_BIT]}}, a[`NARROW_TOP_BIT:0]};
      w = {{(PC_W-`WIDE_TOP_BIT-1){a[`WIDE_TOP_BIT]}}, a[`WIDE_TOP_BIT:0]};
      return wide ? (a == w) : (a == n);
   endfunction

   logic [1:0]                      fetch_ctl_q;
   logic [1:0]                      fetch_stage_q;
   logic [1:0]                      data_ctl_q;
   logic [PC_W-1:0]                 exception_address_q;
   logic [31:0]                     exception_summary_q;
   logic [31:0]                     exc_form_q;
   logic [31:0]                     mem_fault_q;
   logic [31:0]                     fault_form_q;
   logic [3:0]                      rmw_cnt_q;
   logic                            rmw_act_q;
   logic [1:0]                      replay_slot_q;
   logic                            replay_armed_q;
   logic [2:0]                      lock_cnt_q;
   ipr_trap_lock_pkg::lock_state_t  lock_st_q;
   logic                            bus_req;
   logic                            bus_take;

   assign bus_req  = avs_req.read | avs_req.write;
   assign bus_take = bus_req & ~avs_rsp_q.waitrequest;

   // ---------------------------------------------------------------
   // Register bus slave
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_rsp_q <= '{waitrequest: 1'b1, readdata: 32'h0};
      end else begin
         avs_rsp_q.waitrequest <= ~(bus_req & avs_rsp_q.waitrequest);
         if (avs_req.read && avs_rsp_q.waitrequest) begin
            unique case (avs_req.address)
               `REG_FETCH_CTL:   avs_rsp_q.readdata <= {30'h0, fetch_stage_q};
               `REG_DATA_CTL:    avs_rsp_q.readdata <= {30'h0, data_ctl_q};
               `REG_STATUS:      avs_rsp_q.readdata <= {8'h0, replay_armed_q,
                                    lock_q, 4'h0, fetch_ctl_q,
                                    {(16-GROUPS){1'b0}}, sb_busy_q};
               `REG_EXCEPTION_ADDRESS_LO: avs_rsp_q.readdata <= exception_address_q[31:0];
               `REG_EXCEPTION_ADDRESS_HI: avs_rsp_q.readdata <= exception_address_q[63:32];
               `REG_EXC_SUMMARY: avs_rsp_q.readdata <= exception_summary_q;
               `REG_MEM_FAULT:   avs_rsp_q.readdata <= mem_fault_q;
               `REG_FAULT_FORM:  avs_rsp_q.readdata <= exc_form_q;
               default:          avs_rsp_q.readdata <= 32'h0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Address-width control
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_stage_q <= `CTL_RESET;
         fetch_ctl_q   <= `CTL_RESET;
         data_ctl_q    <= `CTL_RESET;
      end else begin
         if (bus_take && avs_req.write && avs_req.address == `REG_FETCH_CTL)
            fetch_stage_q <= avs_req.writedata[1:0];
         if (fetch_ctl_retire)
            fetch_ctl_q <= fetch_stage_q;
         if (bus_take && avs_req.write && avs_req.address == `REG_DATA_CTL)
            data_ctl_q <= avs_req.writedata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_mode_q <= '0;
      end else begin
         addr_mode_q.dtb_double_wide   <= fetch_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.jsr_cmp_wide      <= fetch_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.vpc_wide          <= fetch_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.fetch_acv_wide    <= fetch_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.fetch_form_wide   <= fetch_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.fetch_form_narrow <= fetch_ctl_q[`CTL_NARROW_BIT];
         addr_mode_q.data_form_wide    <= data_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.data_acv_wide     <= data_ctl_q[`CTL_WIDE_BIT];
         addr_mode_q.data_form_narrow  <= data_ctl_q[`CTL_NARROW_BIT];
      end
   end

   // Fetch checks only privileged jumps and returns; data checks every valid address
   always_ff @(posedge clk) begin
      if (rst) begin
         fetch_illegal_q <= 1'b0;
         data_acv_q      <= 1'b0;
      end else begin
         fetch_illegal_q <= (priv_jsr | priv_ret_to_priv) &
                            ~ext_ok(fetch_target, fetch_ctl_q[`CTL_WIDE_BIT]);
         data_acv_q      <= data_va_valid &
                            ~ext_ok(data_va, data_ctl_q[`CTL_WIDE_BIT]);
      end
   end

   // ---------------------------------------------------------------
   // Scoreboard groups
   // ---------------------------------------------------------------
   // Issue sets a group, retire clears it; set wins
   for (genvar g = 0; g < GROUPS; g++) begin : g_sb
      always_ff @(posedge clk) begin
         if (rst)
            sb_busy_q[g] <= 1'b0;
         else if (sb_wr_issue && sb_wr_group == g)
            sb_busy_q[g] <= 1'b1;
         else if (sb_wr_retire && sb_retire_group == g)
            sb_busy_q[g] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read-modify-write sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rmw_act_q      <= 1'b0;
         rmw_cnt_q      <= 4'h0;
         rmw_wr_issue_q <= 1'b0;
      end else begin
         rmw_wr_issue_q <= 1'b0;
         if (rmw_rd_issue && !rmw_act_q) begin
            rmw_act_q <= 1'b1;
            rmw_cnt_q <= 4'h1;
         end else if (rmw_act_q) begin
            rmw_cnt_q <= rmw_cnt_q + 4'h1;
            if ((rmw_cnt_q >= 4'(`RMW_MIN_CYCLES - 1) && rmw_wr_ready) ||
                rmw_cnt_q == 4'(`RMW_MAX_CYCLES - 1)) begin
               rmw_wr_issue_q <= 1'b1;
               rmw_act_q      <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Replay trap ordering and dirty-check cancel
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         mem_issue_block_q <= 1'b0;
      else if (replay_trap)
         mem_issue_block_q <= 1'b1;
      else if (refetch_issue)
         mem_issue_block_q <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         replay_armed_q       <= 1'b0;
         replay_slot_q        <= 2'h0;
         dirty_check_cancel_q <= 1'b0;
      end else begin
         dirty_check_cancel_q <= 1'b0;
         if (replay_trap) begin
            replay_armed_q <= 1'b1;
            replay_slot_q  <= replay_pc;
         end else if (replay_armed_q && iq_enq_valid && iq_enq_pc == replay_slot_q) begin
            replay_armed_q       <= 1'b0;
            dirty_check_cancel_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Exception state lock
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_st_q    <= ipr_trap_lock_pkg::LOCK_OPEN;
         lock_cnt_q   <= 3'h0;
         exc_trap_q   <= 1'b0;
         exc_replay_q <= 1'b0;
      end else begin
         exc_trap_q   <= 1'b0;
         exc_replay_q <= 1'b0;
         unique case (lock_st_q)
            ipr_trap_lock_pkg::LOCK_OPEN: begin
               if (exc_event) begin
                  lock_st_q  <= ipr_trap_lock_pkg::LOCK_HELD;
                  lock_cnt_q <= 3'h0;
                  exc_trap_q <= 1'b1;
               end
            end
            ipr_trap_lock_pkg::LOCK_HELD: begin
               exc_replay_q <= exc_event;
               if (pal_retire)
                  lock_cnt_q <= lock_cnt_q + 3'h1;
               if (pal_retire &&
                   (pal_taken_branch || lock_cnt_q == 3'(`LOCK_INSNS - 1)))
                  lock_st_q <= ipr_trap_lock_pkg::LOCK_OPEN;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         lock_q <= 1'b0;
      else
         lock_q <= (lock_st_q == ipr_trap_lock_pkg::LOCK_OPEN) ? exc_event :
                   !(pal_retire && (pal_taken_branch ||
                     lock_cnt_q == 3'(`LOCK_INSNS - 1)));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         exception_address_q <= '0;
         exception_summary_q  <= 32'h0;
         exc_form_q <= 32'h0;
      end else if (exc_event && lock_st_q == ipr_trap_lock_pkg::LOCK_OPEN) begin
         exception_address_q <= exc_pc;
         exception_summary_q  <= exc_summary_in;
         exc_form_q <= exc_fetch_form_in;
      end
   end

   // Data fault state is outside the lock
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_fault_q  <= 32'h0;
         fault_form_q <= 32'h0;
      end else if (dfault_event) begin
         mem_fault_q  <= dfault_status;
         fault_form_q <= dfault_form;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_rmw_min_gap: assert property (rmw_rd_issue && !rmw_act_q |-> ##1 !rmw_wr_issue_q [*3])
      else $error("rmw write issued before four cycles");
   a_rmw_max_gap: assert property (rmw_rd_issue && !rmw_act_q |-> ##[4:9] rmw_wr_issue_q)
      else $error("rmw write not issued within nine cycles");
   a_replay_block: assert property (replay_trap |=> mem_issue_block_q)
      else $error("newer memory ops not blocked after replay");
   a_cancel_slot: assert property (dirty_check_cancel_q |-> $past(iq_enq_pc) == $past(replay_slot_q))
      else $error("dirty check cancelled at wrong slot");
   a_fetch_legal: assert property (!priv_jsr && !priv_ret_to_priv |=> !fetch_illegal_q)
      else $error("illegal fetch flagged without privileged jump");
   a_fetch_retire: assert property (!fetch_ctl_retire |=> $stable(fetch_ctl_q))
      else $error("fetch control changed without retire");
   a_lock_hold: assert property (exc_trap_q && !(pal_retire && pal_taken_branch) |->
      lock_q ##1 (lock_q && $stable(exception_address_q)))
      else $error("exception state not locked after trap");
   a_lock_stable: assert property (lock_q && exc_event |=> $stable(exception_summary_q) && exc_replay_q)
      else $error("locked exception state overwritten");
   a_unlock_branch: assert property (lock_q && pal_retire && pal_taken_branch |=> !lock_q)
      else $error("taken branch retire did not unlock");
   a_data_unlocked: assert property (dfault_event |=> mem_fault_q == $past(dfault_status))
      else $error("data fault status not updated");
   a_mode_follow: assert property (##1 addr_mode_q.vpc_wide == $past(fetch_ctl_q[0]))
      else $error("fetch width mode not following control");

   c_replay_cancel: cover property (replay_trap ##[1:8] dirty_check_cancel_q);
   c_lock_replay:   cover property (exc_trap_q ##[1:6] exc_replay_q);
   c_rmw_late:      cover property (rmw_rd_issue ##9 rmw_wr_issue_q);
   c_fetch_bad:     cover property (fetch_illegal_q);

endmodule // ipr_scoreboard_trap_lock

// ### tb.sv
// Self-checking testbench for the scoreboard, replay and trap lock block
`timescale 1ns/1ns
module tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                          clk, rst, rmw_wr, blk, cancel, f_ill, d_acv, trap, replay, lock;
   ipr_trap_lock_pkg::avs_req_t   req;
   ipr_trap_lock_pkg::avs_rsp_t   rsp;
   ipr_trap_lock_pkg::addr_mode_t mode;
   logic sb_wr_issue, sb_wr_retire, rmw_rd_issue, rmw_wr_ready, replay_trap, refetch_issue;
   logic iq_enq_valid, priv_jsr, priv_ret_to_priv, data_va_valid, fetch_ctl_retire;
   logic exc_event, pal_retire, pal_taken_branch, dfault_event;
   logic [2:0]  sb_wr_group, sb_retire_group, g;
   logic [1:0]  replay_pc, iq_enq_pc, p, applied;
   logic [63:0] fetch_target, data_va, exc_pc, pc1, t;
   logic [31:0] exc_summary_in, exc_fetch_form_in, dfault_status, dfault_form, rd, s1;
   logic [7:0]  sb_busy;
   int          failures, comparisons, seed, n;

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Design
   // ---------------------------------------------------------------
   ipr_scoreboard_trap_lock #(.GROUPS(8), .PC_W(64)) i_ipr_scoreboard_trap_lock (
      .clk(clk), .rst(rst), .avs_req(req), .avs_rsp_q(rsp),
      .sb_wr_issue(sb_wr_issue), .sb_wr_group(sb_wr_group), .sb_wr_retire(sb_wr_retire),
      .sb_retire_group(sb_retire_group), .sb_busy_q(sb_busy),
      .rmw_rd_issue(rmw_rd_issue), .rmw_wr_ready(rmw_wr_ready), .rmw_wr_issue_q(rmw_wr),
      .replay_trap(replay_trap), .replay_pc(replay_pc), .refetch_issue(refetch_issue),
      .iq_enq_valid(iq_enq_valid), .iq_enq_pc(iq_enq_pc), .mem_issue_block_q(blk),
      .dirty_check_cancel_q(cancel), .priv_jsr(priv_jsr), .priv_ret_to_priv(priv_ret_to_priv),
      .fetch_target(fetch_target), .data_va_valid(data_va_valid), .data_va(data_va),
      .fetch_ctl_retire(fetch_ctl_retire), .fetch_illegal_q(f_ill), .data_acv_q(d_acv),
      .addr_mode_q(mode), .exc_event(exc_event), .exc_pc(exc_pc),
      .exc_summary_in(exc_summary_in), .exc_fetch_form_in(exc_fetch_form_in),
      .pal_retire(pal_retire), .pal_taken_branch(pal_taken_branch),
      .dfault_event(dfault_event), .dfault_status(dfault_status), .dfault_form(dfault_form),
      .exc_trap_q(trap), .exc_replay_q(replay), .lock_q(lock));

   // ---------------------------------------------------------------
   // Tasks and functions
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Bus cycle held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      logic done;
      int   k;
      @(posedge clk);
      req <= '{read: !wr, write: wr, address: a, writedata: d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
         done = (rsp.waitrequest === 1'b0);
      end while (!done && k < 50);
      rd = rsp.readdata;
      if (!done) chk(0, 1);
      req <= '0;
   endtask

   function automatic logic ill(input logic [63:0] a, input logic w);
      logic [63:0] s;
      s = $signed(a) >>> (w ? 47 : 42);
      return !(s == '1 || s == '0);
   endfunction

   // Fetch control staged, then applied on retire
   task automatic set_mode(input logic fw, input logic fn, input logic dw, input logic dn);
      bus(1, 5'h00, {30'h0, fn, fw});
      bus(1, 5'h04, {30'h0, dn, dw});
      bus(0, 5'h00, 32'h0);
      chk(rd, {fn, fw});
      bus(0, 5'h04, 32'h0);
      chk(rd, {dn, dw});
      bus(0, 5'h08, 32'h0);
      chk(rd[17:16], applied);
      @(posedge clk);
      fetch_ctl_retire <= 1;
      @(posedge clk);
      fetch_ctl_retire <= 0;
      repeat (2) @(posedge clk);
      #1 chk(mode, {fw, fw, fw, fw, fw, fn, dw, dw, dn});
      applied = {fn, fw};
      bus(0, 5'h08, 32'h0);
      chk(rd[17:16], applied);
   endtask

   task automatic enq(input logic [1:0] pc, input logic exp);
      @(posedge clk);
      iq_enq_valid <= 1;
      iq_enq_pc <= pc;
      @(posedge clk);
      iq_enq_valid <= 0;
      #1 chk(cancel, exp);
   endtask

   task automatic rmw(input logic ready, input int exp);
      @(posedge clk);
      rmw_rd_issue <= 1;
      rmw_wr_ready <= ready;
      n = 0;
      do begin
         @(posedge clk);
         rmw_rd_issue <= 0;
         n++;
         #1;
      end while (rmw_wr !== 1'b1 && n < 12);
      chk(n, exp);
   endtask

   task automatic exc(input logic [63:0] pc, input logic [31:0] s);
      @(posedge clk);
      exc_event <= 1;
      exc_pc <= pc;
      exc_summary_in <= s;
      exc_fetch_form_in <= ~s;
      @(posedge clk);
      exc_event <= 0;
      #1;
   endtask

   task automatic retire(input logic taken);
      @(posedge clk);
      pal_retire <= 1;
      pal_taken_branch <= taken;
      @(posedge clk);
      pal_retire <= 0;
      pal_taken_branch <= 0;
      #1;
   endtask

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      #200000;
      failures++;
      end_of_test();
   end

   initial begin
      {sb_wr_issue, sb_wr_retire, rmw_rd_issue, rmw_wr_ready, replay_trap, refetch_issue} = '0;
      {iq_enq_valid, priv_jsr, priv_ret_to_priv, data_va_valid, fetch_ctl_retire} = '0;
      {exc_event, pal_retire, pal_taken_branch, dfault_event} = '0;
      {sb_wr_group, sb_retire_group, replay_pc, iq_enq_pc} = '0;
      {fetch_target, data_va, exc_pc, exc_summary_in, exc_fetch_form_in} = '0;
      {dfault_status, dfault_form} = '0;
      req = '0;
      rst = 1;
      seed = 9955;
      applied = 2'h0;
      repeat (16) @(posedge clk);
      rst <= 0;
      #1 chk({rsp.waitrequest, lock, blk, sb_busy}, {1'b1, 10'h000});
      bus(1, 5'h1E, 32'hFFFFFFFF);
      bus(0, 5'h1E, 32'h0);
      chk(rd, 32'h0);
      bus(1, 5'h08, 32'hFFFFFFFF);
      bus(0, 5'h08, 32'h0);
      chk(rd, 32'h0);
      $display("test reset and map done");
      for (int i = 0; i < 4; i++) begin
         g = $random(seed);
         @(posedge clk);
         sb_wr_issue <= 1;
         sb_wr_group <= g;
         @(posedge clk);
         sb_wr_retire <= 1;
         sb_retire_group <= g;
         #1 chk(sb_busy, 8'h01 << g);
         @(posedge clk);
         sb_wr_issue <= 0;
         #1 chk(sb_busy, 8'h01 << g);
         @(posedge clk);
         sb_wr_retire <= 0;
         #1 chk(sb_busy, 8'h00);
      end
      $display("test scoreboard done");
      rmw(1, 4);
      rmw(0, 9);
      $display("test read-modify-write done");
      for (int i = 0; i < 3; i++) begin
         p = $random(seed);
         @(posedge clk);
         replay_trap <= 1;
         replay_pc <= p;
         @(posedge clk);
         replay_trap <= 0;
         #1 chk(blk, 1);
         enq(p ^ 2'h1, 0);
         enq(p, 1);
         enq(p, 0);
         @(posedge clk);
         refetch_issue <= 1;
         @(posedge clk);
         refetch_issue <= 0;
         #1 chk(blk, 0);
      end
      $display("test replay done");
      for (int m = 0; m < 2; m++) begin
         set_mode(m[0], !m[0], !m[0], m[0]);
         for (int i = 0; i < 9; i++) begin
            t = {$random(seed), $random(seed)};
            if (i % 3 == 0) t = $signed(t << 21) >>> 21;
            if (i % 3 == 1) t = $signed(t << 16) >>> 16;
            @(posedge clk);
            priv_jsr <= i[0];
            priv_ret_to_priv <= !i[0];
            fetch_target <= t;
            data_va_valid <= 1;
            data_va <= ~t;
            @(posedge clk);
            {priv_jsr, priv_ret_to_priv, data_va_valid} <= '0;
            #1 chk(f_ill, ill(t, m[0]));
            chk(d_acv, ill(~t, !m[0]));
         end
         @(posedge clk);
         fetch_target <= 64'h0123456789ABCDEF;
         repeat (2) @(posedge clk);
         #1 chk(f_ill, 0);
      end
      $display("test address width done");
      pc1 = {$random(seed), $random(seed)};
      s1 = $random(seed);
      exc(pc1, s1);
      chk({trap, replay, lock}, 3'b101);
      exc(~pc1, ~s1);
      chk({trap, replay, lock}, 3'b011);
      @(posedge clk);
      dfault_event <= 1;
      dfault_status <= ~s1;
      dfault_form <= s1;
      @(posedge clk);
      dfault_event <= 0;
      bus(0, 5'h18, 32'h0);
      chk(rd, 32'(~s1));
      bus(0, 5'h0C, 32'h0);
      chk(rd, pc1[31:0]);
      bus(0, 5'h10, 32'h0);
      chk(rd, pc1[63:32]);
      bus(0, 5'h14, 32'h0);
      chk(rd, s1);
      bus(0, 5'h1C, 32'h0);
      chk(rd, 32'(~s1));
      bus(0, 5'h08, 32'h0);
      chk(rd[22], 1);
      for (int i = 0; i < 3; i++) begin
         retire(0);
         chk(lock, 1);
      end
      retire(0);
      chk(lock, 0);
      exc(~pc1, ~s1);
      chk({trap, replay, lock}, 3'b101);
      bus(0, 5'h0C, 32'h0);
      chk(rd, 32'(~pc1[31:0]));
      retire(1);
      chk(lock, 0);
      $display("test trap lock done");
      end_of_test();
   end
endmodule // tb
